// file: common/oad_regs.vh
// Constants for the operand addressing decoder
`ifndef OAD_REGS_VH
`define OAD_REGS_VH
`define OAD_BANK_W        2
`define OAD_REG_W         3
`define OAD_LOWRAM_TOP    8'h80
`define OAD_BITRAM_BASE   8'h20
`define OAD_BIT_SPECIAL_MASK 8'hf8
`define OAD_ZERO16        16'h0000
`define OAD_ZERO8         8'h00
`define OAD_ZERO3         3'h0
// Address space select codes
`define OAD_SPACE_NONE    3'h0
`define OAD_SPACE_IRAM    3'h1
`define OAD_SPACE_SPECIAL 3'h2
`define OAD_SPACE_XDATA   3'h3
`define OAD_SPACE_CODE    3'h4
`define OAD_SPACE_BIT     3'h5
// Source kind codes
`define OAD_SRC_NONE      3'h0
`define OAD_SRC_REG       3'h1
`define OAD_SRC_DIR       3'h2
`define OAD_SRC_IND       3'h3
`define OAD_SRC_IMM8      3'h4
`define OAD_SRC_IMM16     3'h5
`define OAD_SRC_TABLE     3'h6
// Branch kind codes
`define OAD_BR_NONE       3'h0
`define OAD_BR_LONG_CALL  3'h1
`define OAD_BR_LONG_JUMP  3'h2
`define OAD_BR_PAGE_CALL  3'h3
`define OAD_BR_PAGE_JUMP  3'h4
`define OAD_BR_REL        3'h5
// Opcode fields
`define OAD_OP_LONG_JUMP  8'h02
`define OAD_OP_LONG_CALL  8'h12
`define OAD_OP_SHORT_JUMP 8'h80
`define OAD_OP_POINTER_LOAD 8'h90
`define OAD_OP_TABLE_POINTER 8'h93
`define OAD_OP_MOVC_PC    8'h83
`define OAD_OP_PUSH       8'hc0
`define OAD_OP_POP        8'hd0
`define OAD_OP_XDATA_PTR_R 8'he0
`define OAD_OP_XDATA_PTR_W 8'hf0
`define OAD_LO_PAGE       4'h1
`define OAD_LO_DIRECT     4'h5
`define OAD_LO_IMM        4'h4
`endif

// file: rtl/oad_decoder.v
// Operand addressing decoder for an 8-bit core
`timescale 1ns/10ps
`include "oad_regs.vh"
module oad_decoder #(
    parameter ADDR_W = 16
) (
    // Clock and reset
    input  wire              mclk,
    input  wire              rst,
    // Instruction bytes and core state
    input  wire              instr_valid,
    input  wire [7:0]        opcode,
    input  wire [7:0]        byte2,
    input  wire [7:0]        byte3,
    input  wire [1:0]        bank_sel,
    input  wire [7:0]        r0_value,
    input  wire [7:0]        r1_value,
    input  wire [7:0]        stack_pointer,
    input  wire [15:0]       data_pointer,
    input  wire [7:0]        accumulator,
    input  wire [ADDR_W-1:0] next_pc,
    // Decoded operand outputs
    output reg               dec_valid,
    output reg  [7:0]        reg_addr,
    output reg               reg_hit,
    output reg  [7:0]        direct_addr,
    output reg  [2:0]        direct_space,
    output reg  [7:0]        ind_addr,
    output reg  [15:0]       ind_full_target_address,
    output reg  [2:0]        ind_space,
    output reg  [7:0]        imm8,
    output reg  [15:0]       imm16,
    output reg  [2:0]        src_kind,
    output reg               dst_is_src,
    output reg               dst_legal,
    output reg  [15:0]       table_addr,
    output reg  [2:0]        branch_kind,
    output reg  [ADDR_W-1:0] branch_target
);
    reg [7:0]        reg_addr_next;
    reg              reg_hit_next;
    reg [7:0]        direct_addr_next;
    reg [2:0]        direct_space_next;
    reg [7:0]        ind_addr_next;
    reg [15:0]       ind_full_target_address_next;
    reg [2:0]        ind_space_next;
    reg [7:0]        imm8_next;
    reg [15:0]       imm16_next;
    reg [2:0]        src_kind_next;
    reg              dst_is_src_next;
    reg              dst_legal_next;
    reg [15:0]       table_addr_next;
    reg [2:0]        branch_kind_next;
    reg [ADDR_W-1:0] branch_target_next;
    reg [7:0]        bit_byte;
    reg [7:0]        dir_byte;
    reg              is_move;
    reg              is_rel;
    reg              is_ind;
    reg              is_movx_ri;
    reg              is_bit;
    reg              rel_in_byte3;
    reg [ADDR_W-1:0] rel_ext;
    reg [ADDR_W-1:0] rel_target;
    wire [3:0]       hi = opcode[7:4];
    wire [3:0]       lo = opcode[3:0];

    // Opcode class decode on the high digit; digits 1-3, 4-6 and e-f share a branch
    always @* begin
        is_move      = 1'b0;
        is_rel       = 1'b0;
        is_bit       = 1'b0;
        rel_in_byte3 = 1'b0;
        case (hi)
            4'h1, 4'h2, 4'h3: begin
                // Bit test jumps carry the offset last
                is_rel       = (lo == 4'h0);
                is_bit       = (lo == 4'h0);
                rel_in_byte3 = (lo == 4'h0);
            end
            4'h4, 4'h5, 4'h6: begin
                is_rel = (lo == 4'h0);
            end
            4'h7: begin
                is_move = 1'b1;
                is_rel  = (lo == 4'h0);
                is_bit  = (lo == 4'h2);
            end
            4'h8: begin
                is_move = 1'b1;
                is_rel  = (opcode == `OAD_OP_SHORT_JUMP);
                is_bit  = (lo == 4'h2);
            end
            4'h9: begin
                is_bit = (lo == 4'h2);
            end
            4'ha: begin
                is_move = 1'b1;
                is_bit  = (lo == 4'h0) || (lo == 4'h2);
            end
            4'hb: begin
                is_bit       = (lo == 4'h0) || (lo == 4'h2);
                is_rel       = (lo >= 4'h4);
                rel_in_byte3 = (lo >= 4'h4);
            end
            4'hc: begin
                is_bit = (lo == 4'h2);
            end
            4'hd: begin
                // Register form is two bytes, direct form three
                is_bit       = (lo == 4'h2);
                is_rel       = (lo == 4'h5) || lo[3];
                rel_in_byte3 = (lo == 4'h5);
            end
            4'he, 4'hf: begin
                // External moves live here; low digit 2 is not a bit operand
                is_move = 1'b1;
            end
            default: begin
                is_move = 1'b0;
            end
        endcase
    end

    // Bit number to byte address, bit RAM low, special registers on 8 boundaries
    always @* begin
        bit_byte = `OAD_ZERO8;
        if (!byte2[7]) begin
            bit_byte = `OAD_BITRAM_BASE + {4'h0, byte2[6:3]};
        end else begin
            bit_byte = byte2 & `OAD_BIT_SPECIAL_MASK;
        end
    end

    // Relative offset sits in the last byte of the instruction
    always @* begin
        rel_ext = {{(ADDR_W-8){byte2[7]}}, byte2};
        if (rel_in_byte3) begin
            rel_ext = {{(ADDR_W-8){byte3[7]}}, byte3};
        end
        rel_target = next_pc + rel_ext;
    end

    always @* begin
        reg_addr_next      = {3'h0, bank_sel, opcode[2:0]};
        reg_hit_next       = 1'b0;
        direct_addr_next   = `OAD_ZERO8;
        direct_space_next  = `OAD_SPACE_NONE;
        ind_addr_next      = `OAD_ZERO8;
        ind_full_target_address_next    = `OAD_ZERO16;
        ind_space_next     = `OAD_SPACE_NONE;
        imm8_next          = byte2;
        imm16_next         = {byte2, byte3};
        src_kind_next      = `OAD_SRC_NONE;
        dst_is_src_next    = 1'b0;
        dst_legal_next     = 1'b0;
        table_addr_next    = `OAD_ZERO16;
        branch_kind_next   = `OAD_BR_NONE;
        branch_target_next = next_pc;
        dir_byte           = byte2;
        is_movx_ri = (hi[3:1] == 3'h7) && (lo[3:1] == 3'h1);
        is_ind  = (lo[3:1] == 3'h3) && (hi != 4'h0) && (hi != 4'h1);
        // Register operand in active bank
        if (lo[3]) begin
            reg_addr_next   = {3'h0, bank_sel, opcode[2:0]};
            reg_hit_next    = 1'b1;
            src_kind_next   = `OAD_SRC_REG;
            dst_legal_next  = 1'b1;
            dst_is_src_next = !is_move;
        end
        // Direct byte operand
        if (lo == `OAD_LO_DIRECT || opcode == `OAD_OP_PUSH || opcode == `OAD_OP_POP) begin
            direct_addr_next  = dir_byte;
            if (dir_byte < `OAD_LOWRAM_TOP) begin
                direct_space_next = `OAD_SPACE_IRAM;
            end else begin
                direct_space_next = `OAD_SPACE_SPECIAL;
            end
            src_kind_next     = `OAD_SRC_DIR;
            dst_legal_next    = 1'b1;
            dst_is_src_next   = !is_move;
        end
        // Bit operand, byte address from the mapping above
        if (is_bit) begin
            direct_addr_next  = bit_byte;
            direct_space_next = `OAD_SPACE_BIT;
        end
        // Indirect through R0 or R1, stack or data pointer
        if (is_ind || is_movx_ri) begin
            ind_addr_next   = opcode[0] ? r1_value : r0_value;
            ind_full_target_address_next = {8'h00, ind_addr_next};
            ind_space_next  = is_movx_ri ? `OAD_SPACE_XDATA : `OAD_SPACE_IRAM;
            src_kind_next   = `OAD_SRC_IND;
            dst_legal_next  = 1'b1;
            dst_is_src_next = !is_move && !is_movx_ri;
        end
        if (opcode == `OAD_OP_PUSH || opcode == `OAD_OP_POP) begin
            ind_addr_next   = stack_pointer;
            ind_full_target_address_next = {8'h00, stack_pointer};
            ind_space_next  = `OAD_SPACE_IRAM;
        end
        if (opcode == `OAD_OP_XDATA_PTR_R || opcode == `OAD_OP_XDATA_PTR_W) begin
            ind_full_target_address_next = data_pointer;
            ind_space_next  = `OAD_SPACE_XDATA;
            src_kind_next   = `OAD_SRC_IND;
            dst_legal_next  = 1'b1;
        end
        // Immediate operands are never destinations
        if (lo == `OAD_LO_IMM || (hi == 4'h7 && lo >= 4'h4)) begin
            src_kind_next  = `OAD_SRC_IMM8;
            dst_legal_next = 1'b0;
        end
        if (opcode == `OAD_OP_POINTER_LOAD) begin
            src_kind_next  = `OAD_SRC_IMM16;
            dst_legal_next = 1'b0;
        end
        // Table lookup wraps at 16 bits like the program counter
        if (opcode == `OAD_OP_TABLE_POINTER) begin
            table_addr_next = data_pointer + {8'h00, accumulator};
            ind_space_next  = `OAD_SPACE_CODE;
            src_kind_next   = `OAD_SRC_TABLE;
            dst_legal_next  = 1'b0;
        end
        if (opcode == `OAD_OP_MOVC_PC) begin
            table_addr_next = next_pc[15:0] + {8'h00, accumulator};
            ind_space_next  = `OAD_SPACE_CODE;
            src_kind_next   = `OAD_SRC_TABLE;
            dst_legal_next  = 1'b0;
        end
        // Branch targets
        if (opcode == `OAD_OP_LONG_CALL || opcode == `OAD_OP_LONG_JUMP) begin
            if (opcode == `OAD_OP_LONG_CALL) begin
                branch_kind_next = `OAD_BR_LONG_CALL;
            end else begin
                branch_kind_next = `OAD_BR_LONG_JUMP;
            end
            branch_target_next = {byte2, byte3};
        end else if (lo == `OAD_LO_PAGE) begin
            if (hi[0]) begin
                branch_kind_next = `OAD_BR_PAGE_CALL;
            end else begin
                branch_kind_next = `OAD_BR_PAGE_JUMP;
            end
            branch_target_next = {next_pc[ADDR_W-1:11], opcode[7:5], byte2};
        end else if (is_rel) begin
            branch_kind_next   = `OAD_BR_REL;
            branch_target_next = rel_target;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            dec_valid     <= 1'b0;
            reg_addr      <= `OAD_ZERO8;
            reg_hit       <= 1'b0;
            direct_addr   <= `OAD_ZERO8;
            direct_space  <= `OAD_SPACE_NONE;
            ind_addr      <= `OAD_ZERO8;
            ind_full_target_address    <= `OAD_ZERO16;
            ind_space     <= `OAD_SPACE_NONE;
            imm8          <= `OAD_ZERO8;
            imm16         <= `OAD_ZERO16;
            src_kind      <= `OAD_SRC_NONE;
            dst_is_src    <= 1'b0;
            dst_legal     <= 1'b0;
            table_addr    <= `OAD_ZERO16;
            branch_kind   <= `OAD_BR_NONE;
            branch_target <= {ADDR_W{1'b0}};
        end else begin
            dec_valid <= instr_valid;
            if (instr_valid) begin
                reg_addr      <= reg_addr_next;
                reg_hit       <= reg_hit_next;
                direct_addr   <= direct_addr_next;
                direct_space  <= direct_space_next;
                ind_addr      <= ind_addr_next;
                ind_full_target_address    <= ind_full_target_address_next;
                ind_space     <= ind_space_next;
                imm8          <= imm8_next;
                imm16         <= imm16_next;
                src_kind      <= src_kind_next;
                dst_is_src    <= dst_is_src_next;
                dst_legal     <= dst_legal_next;
                table_addr    <= table_addr_next;
                branch_kind   <= branch_kind_next;
                branch_target <= branch_target_next;
            end
        end
    end
endmodule

// file: tb/oad_mem_model.sv
// Working register file model of the core's internal RAM
`timescale 1ns/10ps
module oad_mem_model (
    // Active bank from the core
    input  wire logic [1:0] bank_sel,
    // R0 and R1 of that bank
    output logic      [7:0] r0_value,
    output logic      [7:0] r1_value
);
    // Each bank holds distinct pointers so a wrong bank shows up
    assign r0_value = {bank_sel, 6'h15};
    assign r1_value = {bank_sel, 6'h2a};
endmodule

// file: tb/oad_props.sv
// Checker for the operand addressing decoder
`timescale 1ns/10ps
module oad_props #(
    parameter ADDR_W = 16
) (
    input wire logic              mclk, rst, instr_valid, dec_valid, reg_hit,
    input wire logic [7:0]        opcode, byte2, byte3, r0_value, r1_value,
    input wire logic [7:0]        accumulator, reg_addr, ind_addr, imm8,
    input wire logic [1:0]        bank_sel,
    input wire logic [15:0]       data_pointer, imm16, table_addr,
    input wire logic [2:0]        branch_kind,
    input wire logic [ADDR_W-1:0] next_pc, branch_target
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_take; instr_valid; endsequence
    sequence s_page; instr_valid && opcode[3:0] == 4'h1; endsequence
    sequence s_idle; !instr_valid; endsequence
    a_reg_addr: assert property (s_take |=>
        reg_addr == {3'h0, $past(bank_sel), $past(opcode[2:0])}) else $error("reg_addr wrong");
    a_reg_hit: assert property (s_take |=> reg_hit == $past(opcode[3]))
        else $error("reg_hit wrong");
    a_ind_ptr: assert property (instr_valid && opcode[7:1] == 7'h73 |=>
        ind_addr == ($past(opcode[0]) ? $past(r1_value) : $past(r0_value))) else $error("ind_addr wrong");
    a_imm_byte: assert property (s_take |=> dec_valid && imm8 == $past(byte2))
        else $error("imm8 wrong");
    a_imm_word: assert property (s_take |=> imm16 == {$past(byte2), $past(byte3)})
        else $error("imm16 wrong");
    a_long_call: assert property (instr_valid && opcode == 8'h12 |=>
        branch_kind == 3'h1 && branch_target == {$past(byte2), $past(byte3)}) else $error("long call wrong");
    a_page_addr: assert property (s_page |=>
        branch_target == {$past(next_pc[15:11]), $past(opcode[7:5]), $past(byte2)}) else $error("page target");
    a_page_kind: assert property (s_page |=>
        branch_kind == ($past(opcode[4]) ? 3'h3 : 3'h4)) else $error("page kind wrong");
    a_rel_short: assert property (instr_valid && opcode == 8'h80 |=>
        branch_target == $past(next_pc) + {{8{$past(byte2[7])}}, $past(byte2)}) else $error("rel target");
    a_table_data_pointer: assert property (instr_valid && opcode == 8'h93 |=>
        table_addr == $past(data_pointer) + {8'h00, $past(accumulator)}) else $error("table addr");
    a_idle_hold: assert property (s_idle |=> !dec_valid && $stable(imm16))
        else $error("idle changed outputs");
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the operand addressing decoder
`timescale 1ns/10ps
module tb_top;
    logic mclk = 1'b0, rst = 1'b1, instr_valid = 1'b0;
    logic [7:0] opcode = 8'h00, byte2 = 8'h00, byte3 = 8'h00, accumulator = 8'h00;
    logic [7:0] stack_pointer = 8'h07, r0_value, r1_value, reg_addr, ind_addr, imm8;
    logic [1:0] bank_sel = 2'h0;
    logic [15:0] data_pointer = 16'h0000, next_pc = 16'h0000, imm16, table_addr, branch_target;
    logic [2:0] branch_kind;
    logic reg_hit;
    logic dec_valid, dst_is_src, dst_legal;
    logic [7:0] direct_addr;
    logic [2:0] direct_space, ind_space, src_kind;
    logic [15:0] ind_full_target_address;
    int n_fail = 0, checked = 0, cyc = 0;
    always #50 mclk = ~mclk;
    oad_mem_model i_mem (.bank_sel(bank_sel), .r0_value(r0_value), .r1_value(r1_value));
    oad_decoder i_dut (.mclk(mclk), .rst(rst), .instr_valid(instr_valid), .opcode(opcode),
        .byte2(byte2), .byte3(byte3), .bank_sel(bank_sel), .r0_value(r0_value),
        .r1_value(r1_value), .stack_pointer(stack_pointer), .data_pointer(data_pointer),
        .accumulator(accumulator), .next_pc(next_pc), .dec_valid(dec_valid), .reg_addr(reg_addr),
        .reg_hit(reg_hit), .direct_addr(direct_addr), .direct_space(direct_space), .ind_addr(ind_addr),
        .ind_full_target_address(ind_full_target_address), .ind_space(ind_space), .imm8(imm8), .imm16(imm16), .src_kind(src_kind),
        .dst_is_src(dst_is_src), .dst_legal(dst_legal),
        .table_addr(table_addr), .branch_kind(branch_kind), .branch_target(branch_target));
    task automatic complete_run;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Inputs move on falling edges, outputs read one cycle later
    task automatic go(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3);
        @(negedge mclk);
        {opcode, byte2, byte3, instr_valid} = {op, b2, b3, 1'b1};
        @(negedge mclk);
        instr_valid = 1'b0;
    endtask
    task automatic t_regs;
        for (int b = 0; b < 4; b++) for (int d = 8; d < 16; d++) begin
            bank_sel = 2'(b);
            go({4'h2, 4'(d)}, 8'h00, 8'h00);
            chk(16'(reg_addr), 16'({b[1:0], 3'(d - 8)}));
            chk(16'(reg_hit), 16'h0001);
            go({4'he, 4'h6 + 4'(b[0])}, 8'h00, 8'h00);
            chk(16'(ind_addr), 16'({b[1:0], b[0] ? 6'h2a : 6'h15}));
        end
        $display("regs done");
    endtask
    task automatic t_imm;
        go(8'h74, 8'ha5, 8'h00);
        chk(16'(imm8), 16'h00a5);
        go(8'h90, 8'hbe, 8'hef);
        chk(imm16, 16'hbeef);
        go(8'h12, 8'hff, 8'hfe);
        chk({13'h0, branch_kind}, 16'h0001);
        chk(branch_target, 16'hfffe);
        go(8'h02, 8'h00, 8'h01);
        chk({13'h0, branch_kind}, 16'h0002);
        chk(branch_target, 16'h0001);
        $display("imm done");
    endtask
    task automatic t_page;
        // Page comes from the following instruction, so 0x0800 is a new page
        next_pc = 16'h0800;
        for (int h = 0; h < 16; h++) begin
            go({4'(h), 4'h1}, 8'h5a, 8'h00);
            chk({13'h0, branch_kind}, h[0] ? 16'h0003 : 16'h0004);
            chk(branch_target, {5'h01, 3'(h >> 1), 8'h5a});
        end
        $display("page done");
    endtask
    task automatic t_rel;
        next_pc = 16'h1000;
        go(8'h80, 8'h80, 8'h00);
        chk(branch_target, 16'h0f80);
        go(8'h80, 8'h7f, 8'h00);
        chk(branch_target, 16'h107f);
        go(8'hb4, 8'h33, 8'hfe);
        chk({13'h0, branch_kind}, 16'h0005);
        chk(branch_target, 16'h0ffe);
        accumulator = 8'h02;
        data_pointer = 16'hffff;
        go(8'h93, 8'h00, 8'h00);
        chk(table_addr, 16'h0001);
        accumulator = 8'hff;
        next_pc = 16'h1234;
        go(8'h83, 8'h00, 8'h00);
        chk(table_addr, 16'h1333);
        $display("rel and table done");
    endtask
    task automatic t_modes;
        data_pointer = 16'h4321;
        bank_sel = 2'h1;
        go(8'he5, 8'h30, 8'h00);
        chk({15'h0, dec_valid}, 16'h0001);
        chk({13'h0, direct_space}, 16'h0001);
        chk(16'(direct_addr), 16'h0030);
        chk({15'h0, dst_is_src}, 16'h0000);
        @(negedge mclk);
        chk({15'h0, dec_valid}, 16'h0000);
        go(8'h25, 8'h90, 8'h00);
        chk({13'h0, direct_space}, 16'h0002);
        chk({15'h0, dst_is_src}, 16'h0001);
        chk({15'h0, dst_legal}, 16'h0001);
        go(8'hd2, 8'h0b, 8'h00);
        chk({13'h0, direct_space}, 16'h0005);
        chk(16'(direct_addr), 16'h0021);
        go(8'hb2, 8'h93, 8'h00);
        chk(16'(direct_addr), 16'h0090);
        go(8'hc0, 8'he0, 8'h00);
        chk(16'(ind_addr), 16'h0007);
        chk({13'h0, ind_space}, 16'h0001);
        go(8'he0, 8'h00, 8'h00);
        chk(ind_full_target_address, 16'h4321);
        chk({13'h0, ind_space}, 16'h0003);
        go(8'hf2, 8'h00, 8'h00);
        chk(ind_full_target_address, 16'h0055);
        chk({13'h0, direct_space}, 16'h0000);
        go(8'h74, 8'h00, 8'h00);
        chk({15'h0, dst_legal}, 16'h0000);
        go(8'h90, 8'h12, 8'h34);
        chk({13'h0, src_kind}, 16'h0005);
        go(8'h93, 8'h00, 8'h00);
        chk({13'h0, src_kind}, 16'h0006);
        chk({15'h0, dst_legal}, 16'h0000);
        $display("modes done");
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        t_regs();
        t_imm();
        t_page();
        t_rel();
        t_modes();
        complete_run();
    end
endmodule
bind oad_decoder oad_props #(.ADDR_W(ADDR_W)) u_props (.mclk(mclk), .rst(rst),
    .instr_valid(instr_valid), .dec_valid(dec_valid), .reg_hit(reg_hit), .opcode(opcode),
    .byte2(byte2), .byte3(byte3), .r0_value(r0_value), .r1_value(r1_value),
    .accumulator(accumulator), .reg_addr(reg_addr), .ind_addr(ind_addr), .imm8(imm8),
    .bank_sel(bank_sel), .data_pointer(data_pointer), .imm16(imm16), .table_addr(table_addr),
    .branch_kind(branch_kind), .next_pc(next_pc), .branch_target(branch_target));
